// *** logic/cbrec_pkg.sv ***
// Package for the capture buffer recorder: offsets, fields, types
package cbrec_pkg;
   localparam int unsigned ADDR_W = 12;
   localparam logic [ADDR_W-1:0] OFF_CTRL = 12'h000;
   localparam logic [ADDR_W-1:0] OFF_CMD = 12'h004;
   localparam logic [ADDR_W-1:0] OFF_STAT = 12'h008;
   localparam logic [ADDR_W-1:0] OFF_IRQ = 12'h00C;
   localparam logic [ADDR_W-1:0] OFF_MASK = 12'h010;
   localparam logic [ADDR_W-1:0] OFF_WPTR = 12'h014;
   localparam logic [ADDR_W-1:0] OFF_FILES = 12'h018;
   localparam logic [ADDR_W-1:0] OFF_LOGCNT = 12'h01C;
   // Control register fields
   localparam int unsigned C_AREA = 0;
   localparam int unsigned C_PROT0 = 2;
   localparam int unsigned C_PROT1 = 3;
   localparam int unsigned C_FULLSTOP = 4;
   localparam int unsigned C_AUTOSAVE = 5;
   localparam int unsigned C_IDLE = 6;
   localparam int unsigned C_LINE = 7;
   localparam int unsigned C_BACKUP = 8;
   localparam int unsigned C_TSUNIT = 9;
   localparam int unsigned C_FSIZE = 12;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [11:0] MAXFILES_RST = 12'h003;
   localparam logic [11:0] MAXFILES_MAX = 12'h800;
   // Command bits
   localparam int unsigned K_RUN = 0;
   localparam int unsigned K_STOP = 1;
   localparam int unsigned K_LOAD = 2;
   // Interrupt bits
   localparam int unsigned I_FULL = 0;
   localparam int unsigned I_REFUSED = 1;
   localparam int unsigned I_FILE = 2;
   localparam int unsigned I_BACKUP = 3;
   localparam int unsigned I_W = 4;
   // Capacities in records of 4 bytes
   localparam longint unsigned BYTES_PER_REC = 4;
   localparam longint unsigned WHOLE_BYTES = 100_000_000;
   localparam longint unsigned HALF_BYTES = 50_000_000;
   localparam logic [25:0] WHOLE_RECS = 26'(WHOLE_BYTES / BYTES_PER_REC);
   localparam logic [25:0] HALF_RECS = 26'(HALF_BYTES / BYTES_PER_REC);
   localparam logic [25:0] MEG_RECS = 26'(1_048_576 / BYTES_PER_REC);
   // Time stamp steps in ns, clock 25 MHz
   localparam int unsigned CLK_NS = 40;
   localparam int unsigned T1US_NS = 1_000;
   localparam int unsigned T10MS_NS = 10_000_000;
   localparam int unsigned CYC_1US = T1US_NS / CLK_NS;
   localparam int unsigned CYC_10MS = T10MS_NS / CLK_NS;
   // Record types, upper two bits of a record
   localparam logic [1:0] RT_DATA = 2'h0;
   localparam logic [1:0] RT_IDLE = 2'h1;
   localparam logic [1:0] RT_STAMP = 2'h2;
   localparam logic [1:0] RT_LINE = 2'h3;
   typedef enum logic [1:0] {AREA_WHOLE, AREA_FIRST, AREA_SECOND} cbrec_area_t;
   typedef enum logic [2:0] {TS_OFF, TS_YMDHM, TS_MDHMS, TS_DHMS10M, TS_100US, TS_10US, TS_1US} cbrec_ts_t;
   typedef struct packed {
      logic valid;
      logic sendSide;
      logic [7:0] dataByte;
      logic [5:0] errFlags;
      logic frameStart;
      logic [6:0] lineState;
   } cbrec_item_t;
   typedef struct packed {
      logic valid;
      logic [25:0] addr;
      logic [31:0] word;
   } cbrec_wr_t;
endpackage : cbrec_pkg

// *** logic/cbrec_recorder.sv ***
// Capture buffer recording control with APB registers
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cbrec_recorder (
   input wire logic clock,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [cbrec_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire cbrec_pkg::cbrec_item_t item,
   output cbrec_pkg::cbrec_wr_t memWr,
   output logic logFileDone,
   output logic backupReq,
   output logic irq
);
   import cbrec_pkg::*;

   // Control and status state
   logic [31:0] ctrl_q, ctrl_d;
   logic [11:0] maxFiles_q, maxFiles_d;
   logic [I_W-1:0] irqStat_q, irqStat_d, irqMask_q, irqMask_d;
   logic running_q, running_d, halted_q, halted_d;
   logic [1:0] filled_q, filled_d;
   logic [25:0] wptr_q, wptr_d, fileCnt_q, fileCnt_d;
   logic [11:0] files_q, files_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d, pslverr_q, pslverr_d;
   cbrec_wr_t memWr_q, memWr_d;
   logic logDone_q, logDone_d, backup_q, backup_d, irq_q, irq_d;
   logic [31:0] idleCnt_q, idleCnt_d, stamp_q, stamp_d;
   logic [31:0] tick_q, tick_d;
   logic [6:0] lastLine_q, lastLine_d;
   logic [31:0] pendWord_q, pendWord_d;
   logic pend_q, pend_d;

   cbrec_area_t area;
   cbrec_ts_t tsUnit;
   logic [25:0] capRecs, baseRecs, fileRecs;
   logic partSel, protHit, wrAcc;
   logic [2:0] fsize;

   function automatic logic [32-1:0] stamp_step(input cbrec_ts_t u);
      // Calendar step is far wider than 16 bits, so the tick is a full word
      unique case (u)
         TS_100US: stamp_step = 32'(100 * CYC_1US);
         TS_10US: stamp_step = 32'(10 * CYC_1US);
         TS_1US: stamp_step = 32'(CYC_1US);
         default: stamp_step = 32'(CYC_10MS);
      endcase
   endfunction : stamp_step

   function automatic logic [31:0] make_rec(input logic [1:0] kind, input logic [29:0] body);
      make_rec = {kind, body};
   endfunction : make_rec

   always_comb begin
      area = cbrec_area_t'(ctrl_q[C_AREA +: 2]);
      tsUnit = cbrec_ts_t'(ctrl_q[C_TSUNIT +: 3]);
      fsize = ctrl_q[C_FSIZE +: 3];
      partSel = (area == AREA_SECOND);
      capRecs = (area == AREA_WHOLE) ? WHOLE_RECS : HALF_RECS;
      baseRecs = partSel ? HALF_RECS : 26'h0;
      fileRecs = (fsize == 3'h0) ? capRecs : 26'(MEG_RECS << (fsize - 3'h1));
      protHit = partSel ? ctrl_q[C_PROT1] : ctrl_q[C_PROT0];
      wrAcc = psel && penable && pwrite;
   end

   always_comb begin
      logic doRun, doStop, doLoad, evFull, evRef, evFile, evBak, wrote;
      logic [31:0] recWord;
      logic [31:0] dataWord;
      // Bit 9 stays clear as a spare between side and error flags
      dataWord = make_rec(RT_DATA, {6'h0, item.lineState & {7{ctrl_q[C_LINE]}},
         item.frameStart, item.errFlags, 1'b0, item.sendSide, item.dataByte});
      ctrl_d = ctrl_q;
      maxFiles_d = maxFiles_q;
      irqMask_d = irqMask_q;
      running_d = running_q;
      halted_d = halted_q;
      filled_d = filled_q;
      wptr_d = wptr_q;
      fileCnt_d = fileCnt_q;
      files_d = files_q;
      idleCnt_d = idleCnt_q;
      stamp_d = stamp_q;
      tick_d = tick_q;
      lastLine_d = lastLine_q;
      pendWord_d = pendWord_q;
      pend_d = pend_q;
      memWr_d = '0;
      logDone_d = 1'b0;
      backup_d = 1'b0;
      evFull = 1'b0;
      evRef = 1'b0;
      evFile = 1'b0;
      evBak = 1'b0;
      wrote = 1'b0;
      recWord = '0;
      doRun = 1'b0;
      doStop = 1'b0;
      doLoad = 1'b0;
      pready_d = 1'b0;
      pslverr_d = 1'b0;
      prdata_d = prdata_q;
      // APB slave: one wait state, answer on second access cycle
      if (psel && penable && !pready_q) begin
         pready_d = 1'b1;
         unique case (paddr)
            OFF_CTRL: prdata_d = ctrl_q;
            OFF_CMD: prdata_d = 32'h0;
            OFF_STAT: prdata_d = {28'h0, filled_q, halted_q, running_q};
            OFF_IRQ: prdata_d = {28'h0, irqStat_q};
            OFF_MASK: prdata_d = {28'h0, irqMask_q};
            OFF_WPTR: prdata_d = {6'h0, wptr_q};
            OFF_FILES: prdata_d = {20'h0, maxFiles_q};
            OFF_LOGCNT: prdata_d = {20'h0, files_q};
            default: begin
               prdata_d = 32'h0;
               pslverr_d = 1'b1;
            end
         endcase
         if (pwrite) begin
            unique case (paddr)
               // Settings frozen while measuring keeps records consistent
               OFF_CTRL: if (!running_q) ctrl_d = pwdata;
               OFF_CMD: begin
                  doRun = pwdata[K_RUN];
                  doStop = pwdata[K_STOP];
                  doLoad = pwdata[K_LOAD];
               end
               OFF_MASK: irqMask_d = pwdata[I_W-1:0];
               OFF_FILES: if (pwdata[11:0] != 12'h0 && pwdata[11:0] <= MAXFILES_MAX)
                  maxFiles_d = pwdata[11:0];
               default: ;
            endcase
         end
      end
      if ((doRun || doLoad) && !running_q) begin
         if (protHit && filled_q[partSel]) begin
            evRef = 1'b1;
         end else begin
            wptr_d = 26'h0;
            filled_d[partSel] = 1'b0;
            running_d = doRun;
            halted_d = 1'b0;
            fileCnt_d = 26'h0;
            files_d = 12'h0;
            idleCnt_d = 32'h0;
            stamp_d = 32'h0;
            tick_d = 32'h0;
            lastLine_d = item.lineState;
            // A record left pending by a stop must not leak into the new run
            pend_d = 1'b0;
         end
      end
      if (doStop && running_q) begin
         running_d = 1'b0;
         evBak = ctrl_q[C_BACKUP];
         backup_d = ctrl_q[C_BACKUP];
      end
      if (running_q && !halted_q) begin
         // Elapsed time counter, step per unit
         if (tick_q >= stamp_step(tsUnit) - 32'h1) begin
            tick_d = 32'h0;
            stamp_d = stamp_q + 32'h1;
         end else begin
            tick_d = tick_q + 32'h1;
         end
         if (item.valid) begin
            // Extra record goes first, data word next cycle if no new item is valid then; idle may shadow stamp
            if (ctrl_q[C_IDLE] && idleCnt_q != 32'h0) begin
               recWord = make_rec(RT_IDLE, idleCnt_q[29:0]);
               pendWord_d = dataWord;
               pend_d = 1'b1;
            end else if (tsUnit != TS_OFF && item.frameStart) begin
               recWord = make_rec(RT_STAMP, stamp_q[29:0]);
               pendWord_d = dataWord;
               pend_d = 1'b1;
            end else begin
               recWord = dataWord;
            end
            wrote = 1'b1;
            idleCnt_d = 32'h0;
         end else if (pend_q) begin
            recWord = pendWord_q;
            pend_d = 1'b0;
            wrote = 1'b1;
         end else if (ctrl_q[C_LINE] && item.lineState != lastLine_q) begin
            recWord = make_rec(RT_LINE, {23'h0, item.lineState});
            wrote = 1'b1;
            idleCnt_d = 32'h0;
         end else if (ctrl_q[C_IDLE]) begin
            idleCnt_d = idleCnt_q + 32'h1;
         end
         lastLine_d = item.lineState;
         if (wrote) begin
            memWr_d.valid = 1'b1;
            memWr_d.addr = baseRecs + wptr_q;
            // Only the recorder writes memory; no bus path edits records
            memWr_d.word = recWord;
            // Any record marks the partition as holding data for protection
            filled_d[partSel] = 1'b1;
            if (wptr_q == capRecs - 26'h1) begin
               evFull = 1'b1;
               wptr_d = 26'h0;
               halted_d = ctrl_q[C_FULLSTOP];
            end else begin
               wptr_d = wptr_q + 26'h1;
            end
            if (ctrl_q[C_AUTOSAVE] && files_q < maxFiles_q) begin
               if (fileCnt_q == fileRecs - 26'h1) begin
                  fileCnt_d = 26'h0;
                  files_d = files_q + 12'h1;
                  logDone_d = 1'b1;
                  evFile = 1'b1;
               end else begin
                  fileCnt_d = fileCnt_q + 26'h1;
               end
            end
         end
      end
      // Write one to clear; a new event wins over the clear
      irqStat_d = irqStat_q;
      if (wrAcc && !pready_q && paddr == OFF_IRQ)
         irqStat_d = irqStat_q & ~pwdata[I_W-1:0];
      irqStat_d = irqStat_d | {evBak, evFile, evRef, evFull};
      irq_d = |(irqStat_d & irqMask_d);
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ctrl_q <= CTRL_RST;
         maxFiles_q <= MAXFILES_RST;
         irqStat_q <= '0;
         irqMask_q <= '0;
         running_q <= 1'b0;
         halted_q <= 1'b0;
         filled_q <= 2'h0;
         wptr_q <= '0;
         fileCnt_q <= '0;
         files_q <= '0;
         prdata_q <= '0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         memWr_q <= '0;
         logDone_q <= 1'b0;
         backup_q <= 1'b0;
         irq_q <= 1'b0;
         idleCnt_q <= '0;
         stamp_q <= '0;
         tick_q <= '0;
         lastLine_q <= '0;
         pendWord_q <= '0;
         pend_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         maxFiles_q <= maxFiles_d;
         irqStat_q <= irqStat_d;
         irqMask_q <= irqMask_d;
         running_q <= running_d;
         halted_q <= halted_d;
         filled_q <= filled_d;
         wptr_q <= wptr_d;
         fileCnt_q <= fileCnt_d;
         files_q <= files_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         memWr_q <= memWr_d;
         logDone_q <= logDone_d;
         backup_q <= backup_d;
         irq_q <= irq_d;
         idleCnt_q <= idleCnt_d;
         stamp_q <= stamp_d;
         tick_q <= tick_d;
         lastLine_q <= lastLine_d;
         pendWord_q <= pendWord_d;
         pend_q <= pend_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign memWr = memWr_q;
   assign logFileDone = logDone_q;
   assign backupReq = backup_q;
   assign irq = irq_q;

   // Refused run or load, mirrored for the checks below
   logic evRefTrack;
   assign evRefTrack = pready_d && wrAcc && paddr == OFF_CMD && (pwdata[K_RUN] || pwdata[K_LOAD])
      && !running_q && protHit && filled_q[partSel];

   chk_whole_capacity: assert property (@(posedge clock) disable iff (rst)
      memWr.valid && ctrl_q[C_AREA +: 2] == 2'h0 |-> memWr.addr < WHOLE_RECS)
      else $error("whole buffer write out of range");
   chk_second_half: assert property (@(posedge clock) disable iff (rst)
      memWr.valid && ctrl_q[C_AREA +: 2] == 2'h2 |-> memWr.addr >= HALF_RECS)
      else $error("second half write below partition");
   chk_record_step: assert property (@(posedge clock) disable iff (rst)
      memWr_d.valid && running_q && !halted_d && wptr_q != capRecs - 26'h1
      |=> wptr_q == $past(wptr_q) + 26'h1)
      else $error("write pointer did not step by one record");
   chk_item_record: assert property (@(posedge clock) disable iff (rst)
      item.valid && running_q && !halted_q |=> memWr.valid)
      else $error("received item left unrecorded");
   chk_run_clears: assert property (@(posedge clock) disable iff (rst)
      $rose(running_q) |-> wptr_q == 26'h0 && !halted_q && tick_q == 32'h0)
      else $error("new run kept old pointer");
   chk_protect_refuse: assert property (@(posedge clock) disable iff (rst)
      evRefTrack |=> $stable(filled_q) && !running_q)
      else $error("protected partition overwritten");
   chk_refuse_flag: assert property (@(posedge clock) disable iff (rst)
      evRefTrack |=> irqStat_q[I_REFUSED])
      else $error("refused run not flagged");
   chk_ring_wrap: assert property (@(posedge clock) disable iff (rst)
      memWr_d.valid && !ctrl_q[C_FULLSTOP] && wptr_q == capRecs - 26'h1 |=> wptr_q == 26'h0 && !halted_q)
      else $error("ring buffer did not wrap");
   chk_full_halt: assert property (@(posedge clock) disable iff (rst)
      halted_q && running_q |-> ##1 !memWr.valid)
      else $error("write while halted");
   // The limit may be lowered between runs, so only each new file is judged
   chk_file_limit: assert property (@(posedge clock) disable iff (rst)
      maxFiles_q >= 12'h1 && maxFiles_q <= MAXFILES_MAX
      && (!logFileDone || $past(files_q) < $past(maxFiles_q)))
      else $error("log file count over limit");
   chk_file_gate: assert property (@(posedge clock) disable iff (rst)
      logFileDone |-> ctrl_q[C_AUTOSAVE])
      else $error("log file done with auto save off");
   chk_idle_gate: assert property (@(posedge clock) disable iff (rst)
      memWr.valid && !ctrl_q[C_IDLE] |-> memWr.word[31:30] != RT_IDLE)
      else $error("idle record while idle time off");
   chk_stamp_gate: assert property (@(posedge clock) disable iff (rst)
      memWr.valid && ctrl_q[C_TSUNIT +: 3] == 3'h0 |-> memWr.word[31:30] != RT_STAMP)
      else $error("stamp record while stamps off");
   chk_stamp_then_data: assert property (@(posedge clock) disable iff (rst)
      memWr.valid && memWr.word[31:30] == RT_STAMP && running_q && !halted_q && !item.valid
      |=> memWr.valid && memWr.word[31:30] == RT_DATA && memWr.word[16])
      else $error("stamp not followed by its character");
   chk_backup_stop: assert property (@(posedge clock) disable iff (rst)
      backupReq |-> $past(running_q) && !running_q && ctrl_q[C_BACKUP])
      else $error("backup without stop");
   chk_tick_range: assert property (@(posedge clock) disable iff (rst)
      running_q |-> tick_q < stamp_step(tsUnit))
      else $error("time stamp tick beyond its unit");
   // Idle and stamp bodies may use bits 23:17, so only data records count
   chk_line_gate: assert property (@(posedge clock) disable iff (rst)
      memWr.valid && !ctrl_q[C_LINE] |-> memWr.word[31:30] != RT_LINE
      && (memWr.word[31:30] != RT_DATA || memWr.word[23:17] == 7'h0))
      else $error("line state recorded while off");
endmodule : cbrec_recorder
`default_nettype wire

// *** verif/cbrec_line_model.sv ***
// Model of the monitored serial line: one item pulse per character
`timescale 1ns/1ps
`default_nettype none
module cbrec_line_model (
   input wire logic clock,
   input wire logic rst,
   input wire logic sendReq,
   input wire cbrec_pkg::cbrec_item_t charIn,
   output cbrec_pkg::cbrec_item_t item
);
   import cbrec_pkg::*;
   cbrec_item_t item_q;
   cbrec_item_t item_d;
   // Fields flip between characters so only valid may qualify them
   always_comb begin
      item_d = sendReq ? charIn : ~item_q;
      item_d.valid = sendReq;
      // Control lines are levels and hold between characters
      item_d.lineState = sendReq ? charIn.lineState : item_q.lineState;
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         item_q <= '0;
      end else begin
         item_q <= item_d;
      end
   end
   assign item = item_q;
endmodule : cbrec_line_model
`default_nettype wire

// *** verif/tb_cbrec_recorder.sv ***
// Testbench for the capture buffer recorder over APB
`timescale 1ns/1ps
`default_nettype none
module tb_cbrec_recorder;
   import cbrec_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic sendReq = 1'b0;
   cbrec_item_t charIn = '0;
   cbrec_item_t item;
   cbrec_wr_t memWr;
   logic logFileDone;
   logic backupReq;
   logic irq;
   logic lastErr;
   logic irqA;
   logic [31:0] v;
   logic [31:0] fw[4] = '{32'h0, 32'h801, 32'h800, 32'h1};
   logic [31:0] fe[4] = '{32'h3, 32'h3, 32'h800, 32'h1};
   int fail_count = 0;
   int tests_run = 0;
   int backups = 0;
   int doneFiles = 0;
   cbrec_wr_t recs[$];
   always #20 clock = ~clock;
   cbrec_recorder i_cbrec_recorder (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .item(item), .memWr(memWr), .logFileDone(logFileDone),
      .backupReq(backupReq), .irq(irq));
   cbrec_line_model i_cbrec_line_model (.clock(clock), .rst(rst), .sendReq(sendReq),
      .charIn(charIn), .item(item));
   always @(posedge clock) begin
      if (memWr.valid === 1'b1) recs.push_back(memWr);
      if (backupReq === 1'b1) backups++;
      if (logFileDone === 1'b1) doneFiles++;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: seen %08h expected %08h", $time, seen, exp);
      end
   endtask : check
   // Request held until pready is seen high at a rising edge, then released there
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) fail_count++;
      rd = prdata;
      lastErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      apb(1'b1, a, d, v);
   endtask : wr
   task automatic rdChk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, v);
      check(v, e);
   endtask : rdChk
   task automatic sendOne(input logic fs, input logic [6:0] ln, input int n);
      int k;
      recs.delete();
      @(posedge clock);
      sendReq <= 1'b1;
      charIn <= '{1'b1, 1'b1, 8'hA5, 6'h15, fs, ln};
      @(posedge clock);
      sendReq <= 1'b0;
      k = 0;
      while (recs.size() < n && k < 20) begin
         @(posedge clock);
         k++;
      end
      repeat (4) @(posedge clock);
   endtask : sendOne
   function automatic logic [31:0] recWord(logic [1:0] t, logic [6:0] ln, logic fs);
      return {t, 6'h00, ln, fs, 6'h15, 1'b0, 1'b1, 8'hA5};
   endfunction : recWord
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : finish_test
   initial begin
      #(40 * 20000);
      fail_count++;
      finish_test();
   end
   initial begin
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      rdChk(OFF_CTRL, CTRL_RST);
      rdChk(OFF_FILES, 32'(MAXFILES_RST));
      apb(1'b0, 12'h020, 32'h0, v);
      check(v, 32'h0);
      check(32'(lastErr), 32'h1);
      for (int i = 0; i < 4; i++) begin
         wr(OFF_FILES, fw[i]);
         rdChk(OFF_FILES, fe[i]);
      end
      $display("test registers done");
      wr(OFF_CTRL, 32'h0);
      wr(OFF_CMD, 32'h1);
      sendOne(1'b0, 7'h55, 1);
      check(32'(recs[$].addr), 32'h0);
      check(recs[$].word, recWord(RT_DATA, 7'h00, 1'b0));
      sendOne(1'b0, 7'h55, 1);
      check(32'(recs[$].addr), 32'h1);
      rdChk(OFF_WPTR, 32'h2);
      wr(OFF_CMD, 32'h2);
      wr(OFF_CTRL, 32'h1 << C_LINE);
      wr(OFF_CMD, 32'h1);
      sendOne(1'b0, 7'h55, 1);
      check(recs[$].word, recWord(RT_DATA, 7'h55, 1'b0));
      // Settings stay frozen during a run
      wr(OFF_CTRL, 32'h0);
      rdChk(OFF_CTRL, 32'h1 << C_LINE);
      wr(OFF_CMD, 32'h2);
      $display("test data records done");
      for (int u = 1; u <= 6; u++) begin
         wr(OFF_CTRL, 32'(u) << C_TSUNIT);
         wr(OFF_CMD, 32'h1);
         sendOne(1'b1, 7'h0, 2);
         check(32'(recs.size()), 32'h2);
         check(32'(recs[0].word[31:30]), 32'(RT_STAMP));
         check(recs[1].word, recWord(RT_DATA, 7'h0, 1'b1));
         check(32'(recs[1].addr), 32'h1);
         sendOne(1'b0, 7'h0, 1);
         check(32'(recs.size()), 32'h1);
         wr(OFF_CMD, 32'h2);
      end
      wr(OFF_CTRL, 32'h1 << C_IDLE);
      wr(OFF_CMD, 32'h1);
      sendOne(1'b0, 7'h0, 1);
      repeat (30) @(posedge clock);
      sendOne(1'b0, 7'h0, 2);
      check(32'(recs[0].word[31:30]), 32'(RT_IDLE));
      check(recs[$].word, recWord(RT_DATA, 7'h0, 1'b0));
      wr(OFF_CMD, 32'h2);
      $display("test extra information done");
      wr(OFF_CTRL, 32'h1);
      wr(OFF_CMD, 32'h1);
      sendOne(1'b0, 7'h0, 1);
      wr(OFF_CMD, 32'h2);
      wr(OFF_CTRL, 32'h5);
      for (int c = 0; c < 2; c++) begin
         wr(OFF_CMD, c ? 32'h4 : 32'h1);
         apb(1'b0, OFF_STAT, 32'h0, v);
         check(32'(v[0]), 32'h0);
         rdChk(OFF_WPTR, 32'h1);
         rdChk(OFF_IRQ, 32'h2);
         wr(OFF_IRQ, 32'h2);
      end
      wr(OFF_CMD, 32'h1);
      wr(OFF_MASK, 32'h0);
      repeat (3) @(negedge clock);
      irqA = irq;
      wr(OFF_MASK, 32'hF);
      repeat (3) @(negedge clock);
      check(32'(irqA ^ irq), 32'h1);
      wr(OFF_IRQ, 32'h2);
      rdChk(OFF_IRQ, 32'h0);
      repeat (3) @(negedge clock);
      check(32'(irq), 32'h0);
      wr(OFF_CTRL, 32'h6);
      wr(OFF_CMD, 32'h1);
      sendOne(1'b0, 7'h0, 1);
      check(32'(recs[$].addr), 32'(HALF_RECS));
      wr(OFF_CMD, 32'h2);
      wr(OFF_CTRL, 32'h1);
      wr(OFF_CMD, 32'h1);
      rdChk(OFF_WPTR, 32'h0);
      wr(OFF_CMD, 32'h2);
      $display("test partitions done");
      wr(OFF_CTRL, 32'h1 << C_BACKUP);
      wr(OFF_CMD, 32'h1);
      backups = 0;
      wr(OFF_CMD, 32'h2);
      repeat (10) @(posedge clock);
      check(32'(backups), 32'h1);
      wr(OFF_CTRL, 32'h0);
      wr(OFF_CMD, 32'h1);
      wr(OFF_CMD, 32'h2);
      repeat (10) @(posedge clock);
      check(32'(backups), 32'h1);
      // Auto save never enabled: no file may complete
      check(32'(doneFiles), 32'h0);
      rdChk(OFF_LOGCNT, 32'h0);
      $display("test backup done");
      finish_test();
   end
endmodule : tb_cbrec_recorder
`default_nettype wire
